/* File: htc_controller.sv */
// Hardware thread syscall controller with APB slave and bus master port.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module htc_controller (
    // Clock, reset and enable.
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus master towards managers and memory.
    output logic             mst_req,
    output logic             mst_rnw,
    output logic      [31:0] master_address_out,
    output logic      [31:0] master_write_data_out,
    input  wire logic [31:0] master_read_data_in,
    input  wire logic        mst_ack,
    // User logic.
    input  wire logic [7:0]  usr_opcode,
    input  wire logic [31:0] usr_arg_one,
    input  wire logic [31:0] usr_arg_two,
    output logic      [3:0]  usr_status,
    output logic      [31:0] usr_result
);

    // ========================================================================
    // Reset synchroniser.
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rst_n = rst_s2_r;

    // ========================================================================
    // State registers.
    htc_pkg::htc_cstate_t cst_r;
    htc_pkg::htc_cstate_t cst_nxt;
    logic [7:0]  tid_r;
    logic [31:0] arg_r;
    logic [3:0]  cmd_r;
    logic [3:0]  sys_r;
    logic [3:0]  sys_req_r;
    logic        sys_req_v_r;
    logic        tid_wr_r;
    logic        run_wr_r;
    logic        soft_rst_r;
    logic [3:0]  ust_r;
    logic        usr_req_r;
    logic [1:0]  hold_r;
    logic [7:0]  op_r;
    logic [31:0] a1_r;
    logic [31:0] a2_r;
    logic [31:0] res_r;
    logic        mreq_r;
    logic        mrnw_r;
    logic [31:0] madr_r;
    logic [31:0] mwd_r;

    // ========================================================================
    // APB decode.
    wire acc    = psel & penable;
    wire wr_acc = acc & pwrite;
    wire wr_tid = wr_acc & (paddr == htc_pkg::OFS_THREAD_IDENTIFIER);
    wire wr_cmd = wr_acc & (paddr == htc_pkg::OFS_THREAD_COMMAND);
    wire wr_arg = wr_acc & (paddr == htc_pkg::OFS_THREAD_ARGUMENT);
    wire cmd_run = wr_cmd & (pwdata[3:0] == htc_pkg::CMD_RUN);
    wire cmd_rst = wr_cmd & (pwdata[3:0] == htc_pkg::CMD_RESET);
    wire [31:0] rd_mux =
        (paddr == htc_pkg::OFS_THREAD_IDENTIFIER) ? {24'h0, tid_r} :
        (paddr == htc_pkg::OFS_VERIFICATION_WORD) ? htc_pkg::VERIFY_VALUE :
        (paddr == htc_pkg::OFS_THREAD_STATUS)     ? {28'h0, sys_r} :
        (paddr == htc_pkg::OFS_THREAD_COMMAND)    ? {28'h0, cmd_r} :
        (paddr == htc_pkg::OFS_THREAD_ARGUMENT)   ? arg_r :
        (paddr == htc_pkg::OFS_USER_RESULT)       ? res_r :
        (paddr == htc_pkg::OFS_DEBUG_STATE)       ?
            {21'h0, cst_r, ust_r, sys_r} : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Read data register, loaded at setup so it is valid in the access phase.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // Software registers; a RESET restarts the engine after the access ends.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tid_r      <= 8'h00;
            arg_r      <= 32'h0000_0000;
            cmd_r      <= htc_pkg::CMD_INIT;
            tid_wr_r   <= 1'b0;
            run_wr_r   <= 1'b0;
            soft_rst_r <= 1'b0;
        end else if (clk_en) begin
            tid_wr_r   <= wr_tid;
            run_wr_r   <= cmd_run;
            soft_rst_r <= cmd_rst;
            if (wr_tid) begin
                tid_r <= pwdata[7:0];
            end
            if (wr_arg) begin
                arg_r <= pwdata;
            end
            if (wr_cmd && !cmd_rst) begin
                cmd_r <= pwdata[3:0];
            end else if (cmd_rst || (cst_r == htc_pkg::CS_WAITRN)) begin
                cmd_r <= htc_pkg::CMD_INIT;
            end
        end
    end

    // ========================================================================
    // System state machine applies controller requests then clears them.
    wire sys_ack = sys_req_v_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_r <= htc_pkg::SYS_NOT_USED;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                sys_r <= htc_pkg::SYS_NOT_USED;
            end else if (sys_req_v_r) begin
                sys_r <= sys_req_r;
            end
        end
    end

    // ========================================================================
    // User state machine: ACK on request, RUN on controller request.
    wire req_pend = (ust_r == htc_pkg::USR_RUN) && (hold_r == 2'h0) &&
                    (usr_opcode != htc_pkg::OP_NOOP);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ust_r  <= htc_pkg::USR_RESET;
            hold_r <= 2'h0;
            op_r   <= htc_pkg::OP_NOOP;
            a1_r   <= 32'h0000_0000;
            a2_r   <= 32'h0000_0000;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                ust_r  <= htc_pkg::USR_RESET;
                hold_r <= 2'h0;
                op_r   <= htc_pkg::OP_NOOP;
            end else if (usr_req_r && ust_r != htc_pkg::USR_RUN) begin
                ust_r  <= htc_pkg::USR_RUN;
                hold_r <= htc_pkg::RUN_HOLDOFF;
                op_r   <= htc_pkg::OP_NOOP;
            end else if (req_pend) begin
                ust_r <= htc_pkg::USR_ACK;
                op_r  <= usr_opcode;
                a1_r  <= usr_arg_one;
                a2_r  <= usr_arg_two;
            end else if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end
        end
    end

    // ========================================================================
    // Manager addresses with identifier field, and mutex number field for lock and unlock only.
    wire [31:0] tid_fld = {24'h0, tid_r} << htc_pkg::ADDR_TID_LSB;
    wire [5:0]  mtx_num = a1_r[htc_pkg::MUTEX_ARG_LSB +: 6];
    wire [31:0] mtx_fld = {26'h0, mtx_num} << htc_pkg::ADDR_MUTEX_LSB;
    wire [31:0] exit_adr = htc_pkg::TM_EXIT_BASE | tid_fld;
    wire [31:0] lock_adr = htc_pkg::MM_LOCK_BASE | mtx_fld | tid_fld;
    wire [31:0] unlk_adr = htc_pkg::MM_UNLOCK_BASE | mtx_fld | tid_fld;
    wire is_exit  = (op_r == htc_pkg::OP_EXIT) || (op_r == htc_pkg::OP_EXITE);
    wire is_bus   = is_exit || (op_r == htc_pkg::OP_READ) ||
                    (op_r == htc_pkg::OP_WRITE) ||
                    (op_r == htc_pkg::OP_LOCK) ||
                    (op_r == htc_pkg::OP_UNLOCK);
    wire granted  = master_read_data_in[htc_pkg::LOCK_GRANT_BIT];
    wire [31:0] req_adr =
        is_exit                        ? exit_adr :
        (op_r == htc_pkg::OP_LOCK)     ? lock_adr :
        (op_r == htc_pkg::OP_UNLOCK)   ? unlk_adr : a1_r;
    wire serve = (ust_r == htc_pkg::USR_ACK) && !usr_req_r;

    // Controller next state.
    always_comb begin
        cst_nxt = cst_r;
        unique case (cst_r)
            htc_pkg::CS_IDLE: begin
                if (serve && is_bus) begin
                    cst_nxt = htc_pkg::CS_BUS;
                end else if (serve && op_r == htc_pkg::OP_SELF) begin
                    cst_nxt = htc_pkg::CS_SELF;
                end else if (serve) begin
                    cst_nxt = htc_pkg::CS_DONE;
                end
            end
            htc_pkg::CS_BUS: begin
                if (mst_ack && is_exit) begin
                    cst_nxt = htc_pkg::CS_SYSREQ;
                end else if (mst_ack && op_r == htc_pkg::OP_LOCK &&
                             !granted) begin
                    cst_nxt = htc_pkg::CS_WAITRN;
                end else if (mst_ack) begin
                    cst_nxt = htc_pkg::CS_DONE;
                end
            end
            htc_pkg::CS_SELF:   cst_nxt = htc_pkg::CS_IDLE;
            htc_pkg::CS_DONE:   cst_nxt = htc_pkg::CS_IDLE;
            htc_pkg::CS_WAITRN: begin
                if (run_wr_r) begin
                    cst_nxt = htc_pkg::CS_DONE;
                end
            end
            htc_pkg::CS_SYSREQ: cst_nxt = htc_pkg::CS_SYSREQ;
            default:            cst_nxt = htc_pkg::CS_IDLE;
        endcase
    end

    // Controller registers, bus master and status requests.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cst_r       <= htc_pkg::CS_IDLE;
            usr_req_r   <= 1'b0;
            sys_req_r   <= htc_pkg::SYS_NOT_USED;
            sys_req_v_r <= 1'b0;
            res_r       <= 32'h0000_0000;
            mreq_r      <= 1'b0;
            mrnw_r      <= 1'b1;
            madr_r      <= 32'h0000_0000;
            mwd_r       <= 32'h0000_0000;
        end else if (clk_en) begin
            cst_r <= soft_rst_r ? htc_pkg::CS_IDLE : cst_nxt;
            if (soft_rst_r || (usr_req_r && ust_r == htc_pkg::USR_RUN)) begin
                usr_req_r <= 1'b0;
            end else if (cst_r == htc_pkg::CS_DONE || run_wr_r ||
                         (serve && cst_r == htc_pkg::CS_IDLE &&
                          op_r == htc_pkg::OP_SELF)) begin
                usr_req_r <= 1'b1;
            end
            if (tid_wr_r) begin
                sys_req_r   <= htc_pkg::SYS_USED;
                sys_req_v_r <= 1'b1;
            end else if (run_wr_r) begin
                sys_req_r   <= htc_pkg::SYS_RUNNING;
                sys_req_v_r <= 1'b1;
            end else if (cst_r == htc_pkg::CS_BUS && mst_ack && is_exit) begin
                sys_req_r   <= (op_r == htc_pkg::OP_EXITE) ?
                               htc_pkg::SYS_FAULT :
                               htc_pkg::SYS_EXITED;
                sys_req_v_r <= 1'b1;
            end else if (cst_r == htc_pkg::CS_BUS && mst_ack &&
                         op_r == htc_pkg::OP_LOCK && !granted) begin
                sys_req_r   <= htc_pkg::SYS_BLOCKED;
                sys_req_v_r <= 1'b1;
            end else if (sys_ack) begin
                sys_req_v_r <= 1'b0;
            end
            if (cst_r == htc_pkg::CS_IDLE && serve && is_bus) begin
                mreq_r <= 1'b1;
                mrnw_r <= (op_r != htc_pkg::OP_WRITE);
                madr_r <= req_adr;
                mwd_r  <= a2_r;
            end else if (mst_ack || soft_rst_r) begin
                mreq_r <= 1'b0;
            end
            if (cst_r == htc_pkg::CS_BUS && mst_ack &&
                op_r == htc_pkg::OP_READ) begin
                res_r <= master_read_data_in;
            end else if (cst_r == htc_pkg::CS_IDLE && serve &&
                         op_r == htc_pkg::OP_SELF) begin
                res_r <= {24'h0, tid_r};
            end
        end
    end

    // Outputs.
    assign mst_req               = mreq_r;
    assign mst_rnw               = mrnw_r;
    assign master_address_out    = madr_r;
    assign master_write_data_out = mwd_r;
    assign usr_status            = ust_r;
    assign usr_result            = res_r;

endmodule : htc_controller

`default_nettype wire

/* File: htc_pkg.sv */
// Package of constants and types for the hardware thread syscall controller.
package htc_pkg;

    // ========================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_THREAD_IDENTIFIER = 8'h00;
    localparam logic [7:0] OFS_VERIFICATION_WORD = 8'h04;
    localparam logic [7:0] OFS_THREAD_STATUS     = 8'h08;
    localparam logic [7:0] OFS_THREAD_COMMAND    = 8'h0c;
    localparam logic [7:0] OFS_THREAD_ARGUMENT   = 8'h10;
    localparam logic [7:0] OFS_USER_RESULT       = 8'h18;
    localparam logic [7:0] OFS_DEBUG_STATE       = 8'h30;

    // Verification word value; the value is arbitrary.
    localparam logic [31:0] VERIFY_VALUE = 32'h5a5a_0001;

    // ========================================================================
    // System status codes.
    localparam logic [3:0] SYS_NOT_USED  = 4'h0;
    localparam logic [3:0] SYS_USED      = 4'h1;
    localparam logic [3:0] SYS_RUNNING   = 4'h2;
    localparam logic [3:0] SYS_EXITED    = 4'h3;
    localparam logic [3:0] SYS_FAULT     = 4'h4;
    localparam logic [3:0] SYS_BLOCKED   = 4'h5;

    // Command codes written to the command register.
    localparam logic [3:0] CMD_INIT  = 4'h0;
    localparam logic [3:0] CMD_RUN   = 4'h1;
    localparam logic [3:0] CMD_RESET = 4'h2;

    // ========================================================================
    // User-side status one-hot codes.
    localparam logic [3:0] USR_RESET = 4'h1;
    localparam logic [3:0] USR_RUN   = 4'h2;
    localparam logic [3:0] USR_ACK   = 4'h4;
    localparam logic [3:0] USR_PAUSE = 4'h8;

    // User opcodes.
    localparam logic [7:0] OP_NOOP   = 8'h00;
    localparam logic [7:0] OP_EXIT   = 8'h01;
    localparam logic [7:0] OP_EXITE  = 8'h09;
    localparam logic [7:0] OP_READ   = 8'h02;
    localparam logic [7:0] OP_WRITE  = 8'h03;
    localparam logic [7:0] OP_SELF   = 8'h04;
    localparam logic [7:0] OP_YIELD  = 8'h05;
    localparam logic [7:0] OP_LOCK   = 8'h06;
    localparam logic [7:0] OP_UNLOCK = 8'h07;

    // ========================================================================
    // Manager register bases and address fields.
    localparam logic [31:0] TM_EXIT_BASE     = 32'h1000_0000;
    localparam logic [31:0] MM_LOCK_BASE     = 32'h2000_0000;
    localparam logic [31:0] MM_UNLOCK_BASE   = 32'h2001_0000;
    localparam int          ADDR_TID_LSB     = 2;
    localparam int          ADDR_MUTEX_LSB   = 10;
    localparam int          MUTEX_ARG_LSB    = 26;
    localparam int          LOCK_GRANT_BIT   = 0;
    localparam logic [1:0]  RUN_HOLDOFF      = 2'h2;

    // Controller states.
    typedef enum logic [2:0] {
        CS_IDLE   = 3'h0,
        CS_BUS    = 3'h1,
        CS_DONE   = 3'h2,
        CS_SELF   = 3'h3,
        CS_WAITRN = 3'h4,
        CS_SYSREQ = 3'h5
    } htc_cstate_t;

endpackage : htc_pkg

/* File: htc_controller_sva.sv */
// Checker of the controller's user side and bus-master behaviour.
`timescale 1ns/10ps
`default_nettype none
module htc_controller_sva (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        resetn,
    // Bus master.
    input wire logic        mst_req,
    input wire logic        mst_rnw,
    input wire logic        mst_ack,
    input wire logic [31:0] master_address_out,
    input wire logic [31:0] master_write_data_out,
    input wire logic [31:0] master_read_data_in,
    // User side.
    input wire logic [7:0]  usr_opcode,
    input wire logic [31:0] usr_arg_one,
    input wire logic [31:0] usr_arg_two,
    input wire logic [3:0]  usr_status,
    input wire logic [31:0] usr_result
);
    // ======================================================================
    // Helpers
    logic [31:0] rd_r;
    logic        run_w;
    logic        ack_w;
    logic        xfer_w;
    // Decoded user status and completed master transfers.
    assign run_w  = (usr_status == htc_pkg::USR_RUN);
    assign ack_w  = (usr_status == htc_pkg::USR_ACK);
    assign xfer_w = mst_req && mst_ack;
    // Keeps the read data of the last completed transfer.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_r <= 32'h0;
        end else if (xfer_w) begin
            rd_r <= master_read_data_in;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // ======================================================================
    // Assertions
    a_ack_first: assert property (
        $rose(mst_req) |-> ack_w) else $error("bus request without ACK");
    a_req_held: assert property (
        mst_req && !mst_ack |=> mst_req && $stable(master_address_out))
        else $error("bus request not held");
    a_run_holdoff: assert property (
        $rose(run_w) |=> run_w [*2]) else $error("request taken in holdoff");
    a_write_args: assert property (
        $rose(mst_req) && !mst_rnw |-> master_address_out == usr_arg_one
        && master_write_data_out == usr_arg_two)
        else $error("write address or data wrong");
    a_read_addr: assert property (
        $rose(mst_req) && usr_opcode == htc_pkg::OP_READ
        |-> mst_rnw && master_address_out == usr_arg_one)
        else $error("read address wrong");
    a_read_load: assert property (
        $rose(run_w) && usr_opcode == htc_pkg::OP_READ |-> usr_result == rd_r)
        else $error("read result not loaded");
    a_self_step: assert property (
        $changed(usr_result) && usr_opcode == htc_pkg::OP_SELF
        |-> usr_result[31:8] == 24'h0 && ack_w ##1 run_w)
        else $error("self result or RUN step wrong");
    a_bus_back: assert property (
        xfer_w && (usr_opcode == htc_pkg::OP_READ || usr_opcode ==
        htc_pkg::OP_WRITE || usr_opcode == htc_pkg::OP_UNLOCK)
        |-> ##[1:4] run_w) else $error("no RUN after bus call");
    a_exit_hold: assert property (
        xfer_w && (usr_opcode == htc_pkg::OP_EXIT || usr_opcode ==
        htc_pkg::OP_EXITE) |=> ack_w [*4]) else $error("exit left ACK");
    // Main scenarios.
    c_write: cover property ($rose(mst_req) && !mst_rnw);
    c_self: cover property ($changed(usr_result) && usr_opcode == 8'h04);
    c_exit: cover property (xfer_w && usr_opcode == htc_pkg::OP_EXITE);
endmodule : htc_controller_sva
`default_nettype wire

/* File: htc_partner.sv */
// Model of the thread user logic and of the manager bus responders.
`timescale 1ns/10ps
`default_nettype none
module htc_partner (
    // Clock, reset and bench controls.
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic [7:0]  op,
    input  wire logic [31:0] a1,
    input  wire logic [31:0] a2,
    input  wire logic [31:0] rdd,
    input  wire logic [1:0]  dly,
    output logic             busy,
    // Towards the controller.
    input  wire logic [3:0]  usr_status,
    input  wire logic        mst_req,
    output logic      [7:0]  usr_opcode,
    output logic      [31:0] usr_arg_one,
    output logic      [31:0] usr_arg_two,
    output logic             mst_ack,
    output logic      [31:0] master_read_data_in
);
    logic       left_r;
    logic [1:0] wait_r;
    // Presents a request whole and holds it until RUN comes back, or until the user status goes to RESET.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            usr_opcode <= htc_pkg::OP_NOOP;
            usr_arg_one <= 32'h0;
            usr_arg_two <= 32'h0;
            busy <= 1'b0;
            left_r <= 1'b0;
        end else if (go) begin
            usr_opcode <= op;
            usr_arg_one <= a1;
            usr_arg_two <= a2;
            busy <= 1'b1;
            left_r <= 1'b0;
        end else if (busy && usr_status != htc_pkg::USR_ACK &&
                     (left_r || usr_status == htc_pkg::USR_RESET)) begin
            usr_opcode <= htc_pkg::OP_NOOP;
            busy <= 1'b0;
        end else if (busy && usr_status != htc_pkg::USR_RUN) begin
            left_r <= 1'b1;
        end
    end
    // Answers a held request after dly cycles; idle data keeps toggling.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mst_ack <= 1'b0;
            wait_r <= 2'h0;
            master_read_data_in <= 32'h0;
        end else if (mst_req && !mst_ack && wait_r == dly) begin
            mst_ack <= 1'b1;
            master_read_data_in <= rdd;
            wait_r <= 2'h0;
        end else begin
            mst_ack <= 1'b0;
            wait_r <= (mst_req && !mst_ack) ? wait_r + 2'h1 : 2'h0;
            master_read_data_in <= ~master_read_data_in;
        end
    end
endmodule : htc_partner
`default_nettype wire

/* File: htc_controller_bench.sv */
// Self-checking bench of the hardware thread syscall controller.
`timescale 1ns/10ps
`default_nettype none
module htc_controller_bench;
    // Stimulus and observed signals.
    logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, pready, pslverr, mst_req, mst_rnw;
    logic mst_ack, busy, clk_en = 1'b1;
    logic [7:0] paddr = 8'h00, op = 8'h00, tid, usr_opcode;
    logic [31:0] pwdata = 32'h0, a1 = 32'h0, a2 = 32'h0, rdd = 32'h0;
    logic [31:0] prdata, q, maddr, mwd, mrd, arg1, arg2, usr_result;
    logic [31:0] cap_addr, cap_wd;
    logic [3:0] usr_status;
    logic [1:0] dly = 2'h0;
    int fail_count = 0, samples_checked = 0, cycles = 0, nbus = 0;
    always #2.5 mclk = ~mclk;
    htc_controller dut_u (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mst_req(mst_req), .mst_rnw(mst_rnw),
        .master_address_out(maddr), .master_write_data_out(mwd),
        .master_read_data_in(mrd), .mst_ack(mst_ack),
        .usr_opcode(usr_opcode), .usr_arg_one(arg1), .usr_arg_two(arg2),
        .usr_status(usr_status), .usr_result(usr_result));
    htc_partner part_u (.mclk(mclk), .resetn(resetn), .go(go), .op(op),
        .a1(a1), .a2(a2), .rdd(rdd), .dly(dly), .busy(busy),
        .usr_status(usr_status), .mst_req(mst_req), .mst_ack(mst_ack),
        .usr_opcode(usr_opcode), .usr_arg_one(arg1), .usr_arg_two(arg2),
        .master_read_data_in(mrd));
    // Records each completed master transfer; cuts a hang short.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (mst_req && mst_ack) begin
            cap_addr <= maddr;
            cap_wd <= mwd;
            nbus <= nbus + 1;
        end
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // One APB transfer at thread base 0; read data lands in q.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("register", q, e);
        check("slave error", {31'h0, pslverr}, 32'h0);
    endtask : rd_chk
    task automatic wait_usr(input logic [3:0] s, input int lim);
        int n;
        n = 0;
        while (usr_status !== s && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("user status", {28'h0, usr_status}, {28'h0, s});
    endtask : wait_usr
    task automatic run_op(input logic [7:0] o, input logic [31:0] x, y,
                          input int lim);
        int n;
        n = 0;
        @(posedge mclk);
        go <= 1'b1;
        op <= o;
        a1 <= x;
        a2 <= y;
        @(posedge mclk);
        go <= 1'b0;
        #1;
        while (busy === 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : run_op
    function automatic logic [31:0] mgr(input logic [31:0] b,
                                        input logic [5:0] m);
        return b | ({26'h0, m} << 10) | ({24'h0, tid} << 2);
    endfunction : mgr
    task automatic t_start(input logic [7:0] id);
        tid = id;
        apb(1'b1, htc_pkg::OFS_THREAD_IDENTIFIER, {24'h0, id});
        repeat (3) @(posedge mclk);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h1);
        rd_chk(htc_pkg::OFS_VERIFICATION_WORD, htc_pkg::VERIFY_VALUE);
        rd_chk(8'h14, 32'h0);
        apb(1'b1, htc_pkg::OFS_THREAD_ARGUMENT, 32'h600d_f00d);
        rd_chk(htc_pkg::OFS_THREAD_ARGUMENT, 32'h600d_f00d);
        clk_en <= 1'b0;
        apb(1'b1, htc_pkg::OFS_THREAD_ARGUMENT, 32'h0);
        clk_en <= 1'b1;
        rd_chk(htc_pkg::OFS_THREAD_ARGUMENT, 32'h600d_f00d);
        apb(1'b1, htc_pkg::OFS_THREAD_COMMAND, 32'h1);
        wait_usr(htc_pkg::USR_RUN, 5);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h2);
    endtask : t_start
    task automatic t_calls();
        int n0;
        run_op(htc_pkg::OP_SELF, 32'h0, 32'h0, 20);
        check("self result", usr_result, {24'h0, tid});
        n0 = nbus;
        run_op(htc_pkg::OP_YIELD, 32'h0, 32'h0, 20);
        run_op(8'h08, 32'h0, 32'h0, 20);
        check("bus count", 32'(nbus), 32'(n0));
        dly = 2'h3;
        rdd = 32'hc3a5_0f1e;
        run_op(htc_pkg::OP_READ, 32'h4000_0010, 32'h0, 40);
        check("read result", usr_result, rdd);
        run_op(htc_pkg::OP_WRITE, 32'h4000_0020, 32'h1234_abcd, 40);
        check("write data", cap_wd, 32'h1234_abcd);
        check("kept result", usr_result, rdd);
        dly = 2'h0;
        rdd = 32'h1;
        run_op(htc_pkg::OP_LOCK, {6'h2d, 26'h0}, 32'h0, 40);
        check("lock addr", cap_addr, mgr(32'h2000_0000, 6'h2d));
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h2);
        run_op(htc_pkg::OP_UNLOCK, {6'h2d, 26'h0}, 32'h0, 40);
        check("unlock addr", cap_addr, mgr(32'h2001_0000, 6'h2d));
        check("unlock done", {31'h0, busy}, 32'h0);
        rdd = 32'h0;
        run_op(htc_pkg::OP_LOCK, {6'h05, 26'h0}, 32'h0, 30);
        wait_usr(htc_pkg::USR_ACK, 1);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h5);
        rd_chk(htc_pkg::OFS_THREAD_COMMAND, 32'h0);
        apb(1'b1, htc_pkg::OFS_THREAD_COMMAND, 32'h1);
        wait_usr(htc_pkg::USR_RUN, 5);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h2);
    endtask : t_calls
    task automatic t_exit(input logic [7:0] o, input logic [31:0] st);
        run_op(o, 32'h0, 32'h0, 30);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, st);
        check("exit addr", cap_addr, mgr(32'h1000_0000, 6'h0));
        apb(1'b1, htc_pkg::OFS_THREAD_COMMAND, 32'h2);
        wait_usr(htc_pkg::USR_RESET, 4);
        rd_chk(htc_pkg::OFS_THREAD_STATUS, 32'h0);
    endtask : t_exit
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Main sequence.
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_start(8'h2a);
        t_calls();
        t_exit(htc_pkg::OP_EXIT, 32'h3);
        t_start(8'h15);
        t_exit(htc_pkg::OP_EXITE, 32'h4);
        wrap_up();
    end
endmodule : htc_controller_bench
bind htc_controller htc_controller_sva chk_u (.mclk(mclk), .resetn(resetn),
    .mst_req(mst_req), .mst_rnw(mst_rnw), .mst_ack(mst_ack),
    .master_address_out(master_address_out), .usr_opcode(usr_opcode),
    .master_write_data_out(master_write_data_out),
    .master_read_data_in(master_read_data_in), .usr_arg_one(usr_arg_one),
    .usr_arg_two(usr_arg_two), .usr_status(usr_status),
    .usr_result(usr_result));
`default_nettype wire
